/* File: rtl/usc_pkg.sv */
// constants and carrier types for the uplink schedule and configuration block
// Summary of operation
// - The configured uplink interval is whole minutes and only values from 5 to 1440 are taken.
// - With the adaptive interval mode on, the interval in use is raised to the data-rate minimum.
// - Single-telegram minimums are 180, 120, 60, 30 and 15 minutes for DR0 to DR3 and DR4-DR5.
// - Two-telegram formats double those minimums, from 360 minutes at DR0 to 30 at DR4-DR5.
// - Downlink configuration is taken only on port 2 inside the receive window after an uplink.
// - A downlink command is a 0x00 byte, a type byte, a length byte and that many data bytes.
// - All time comes from the meter clock taken as standard time; no time base of its own.
// - The signed minute offset is subtracted from the meter timestamp before it is sent.
// - A zero offset sends the meter timestamp unchanged.
// - A daylight saving setting in the meter is ignored; timestamps stay in standard time.
// - Each block-coded telegram opens with the format byte, then data information blocks.
// - Each block is a data information field, a value information field, then the data.
// - The plain-text format sends readings as text without the block structure.
// - With the configuration lock on, bus writes are refused until the right access key is shown; downlink commands still apply.
// - An erroneous or unread value has bits 4 and 5 of its data information field set to 11.
package usc_pkg;
   // register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_IVL = 8'h04;
   localparam logic [7:0] A_OFF = 8'h08;
   localparam logic [7:0] A_KEY = 8'h0C;
   localparam logic [7:0] A_STAT = 8'h10;
   // control fields and reset values
   localparam int C_MODE = 0;
   localparam int C_TWO = 1;
   localparam int C_LOCK = 2;
   localparam int C_FMT = 8;
   localparam logic RST_MODE = 1'b1;
   localparam logic [7:0] RST_FMT = 8'h15;
   localparam logic [7:0] FMT_PLAIN = 8'h20;
   // interval limits in minutes
   localparam int IW = 11;
   localparam logic [10:0] IVL_MIN = 11'h005;
   localparam logic [10:0] IVL_MAX = 11'h5A0;
   localparam logic [10:0] RST_IVL = 11'h03C;
   localparam logic [10:0] ECO_DR0 = 11'h0B4;
   localparam logic [10:0] ECO_DR1 = 11'h078;
   localparam logic [10:0] ECO_DR2 = 11'h03C;
   localparam logic [10:0] ECO_DR3 = 11'h01E;
   localparam logic [10:0] ECO_DR4 = 11'h00F;
   // downlink framing
   localparam logic [7:0] DL_PORT = 8'h02;
   localparam logic [7:0] DL_LEAD = 8'h00;
   localparam logic [7:0] DLT_IVL = 8'h01;
   localparam logic [7:0] DLT_MODE = 8'h02;
   localparam logic [7:0] DLT_OFF = 8'h03;
   localparam logic [7:0] DLT_LOCK = 8'h04;
   localparam logic [7:0] DLT_FMT = 8'h05;
   // telegram coding
   localparam logic [7:0] DIF_ERR = 8'h30;
   localparam logic [1:0] DAT_LAST = 2'h3;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } usc_apb_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] port;
      logic [7:0] data;
      logic last;
   } usc_dl_t;

   typedef struct packed {
      logic valid;
      logic [7:0] ctype;
      logic [31:0] value;
   } usc_cfg_t;

   typedef struct packed {
      logic valid;
      logic err;
      logic last;
      logic [7:0] dif;
      logic [7:0] vif;
      logic [31:0] data;
   } usc_rd_t;
endpackage

/* File: rtl/usc_dl_parse.sv */
// downlink configuration command parser
`timescale 1ns/1ps
module usc_dl_parse (
   // clock and reset
   input logic pclk,
   input logic presetn,
   input logic ce,
   // radio side
   input usc_pkg::usc_dl_t dl,
   input logic rx_window,
   // decoded command
   output usc_pkg::usc_cfg_t cfg
);
   typedef enum logic [2:0] {P_HDR, P_TYP, P_LEN, P_DAT, P_SKIP} usc_pst_t;
   usc_pst_t st_q;
   logic [7:0] typ_q;
   logic [7:0] len_q;
   logic [31:0] val_q;
   usc_pkg::usc_cfg_t cfg_q;

   // only port 2 bytes inside the receive window count
   wire take = dl.valid & rx_window & (dl.port == usc_pkg::DL_PORT);
   wire [31:0] val_d = {val_q[23:0], dl.data};

   assign cfg = cfg_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= P_HDR;
         typ_q <= 8'h00;
         len_q <= 8'h00;
         val_q <= 32'h0000_0000;
         cfg_q <= '0;
      end else if (ce) begin
         cfg_q.valid <= 1'b0;
         if (!rx_window) begin
            st_q <= P_HDR;
         end else if (take) begin
            case (st_q)
               P_HDR: st_q <= (dl.data == usc_pkg::DL_LEAD) ? P_TYP : P_SKIP;
               P_TYP: begin
                  typ_q <= dl.data;
                  st_q <= P_LEN;
               end
               P_LEN: begin
                  len_q <= dl.data;
                  val_q <= 32'h0000_0000;
                  st_q <= (dl.data == 8'h00) ? P_SKIP : P_DAT;
               end
               P_DAT: begin
                  val_q <= val_d;
                  len_q <= len_q - 8'h01;
                  if (len_q == 8'h01) begin
                     cfg_q <= '{valid: 1'b1, ctype: typ_q, value: val_d};
                     st_q <= P_SKIP;
                  end
               end
               default: st_q <= P_SKIP;
            endcase
            // a frame cut short before its length is reached is dropped
            if (dl.last) begin
               st_q <= P_HDR;
            end
         end
      end
   end
endmodule // usc_dl_parse

/* File: rtl/usc_top.sv */
// uplink interval scheduler, configuration registers and telegram framer
`timescale 1ns/1ps
module usc_top #(
   parameter logic [31:0] DEV_KEY = 32'h1234_5678 // arbitrary value
)(
   // clock and reset
   input logic pclk,
   input logic presetn,
   input logic ce,
   // apb slave
   input usc_pkg::usc_apb_req_t apb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // host meter
   input logic minute_tick_pin,
   input logic [31:0] meter_time,
   output logic [31:0] utc_time,
   // radio mac
   input logic [2:0] data_rate,
   input logic uplink_done,
   input usc_pkg::usc_dl_t dl,
   input logic rx_window,
   output logic uplink_req,
   output logic [10:0] eff_interval,
   // readings in
   input usc_pkg::usc_rd_t rd,
   input logic tel_start,
   output logic rd_ready,
   // telegram bytes out
   input logic tx_ready,
   output logic tx_valid,
   output logic [7:0] tx_byte,
   output logic tx_last
);
   typedef enum logic [2:0] {T_IDLE, T_FMT, T_DIB, T_DIF, T_VIF, T_DAT} usc_tst_t;

   function automatic logic ivl_ok(input logic [31:0] v);
      ivl_ok = (v[31:11] == 21'h0) && (v[10:0] >= usc_pkg::IVL_MIN)
               && (v[10:0] <= usc_pkg::IVL_MAX);
   endfunction

   function automatic logic [10:0] eco_min(input logic [2:0] dr, input logic two);
      logic [10:0] m;
      case (dr)
         3'h0: m = usc_pkg::ECO_DR0;
         3'h1: m = usc_pkg::ECO_DR1;
         3'h2: m = usc_pkg::ECO_DR2;
         3'h3: m = usc_pkg::ECO_DR3;
         default: m = usc_pkg::ECO_DR4;
      endcase
      eco_min = two ? {m[9:0], 1'b0} : m;
   endfunction

   // configuration state
   logic mode_q;
   logic two_q;
   logic lock_q;
   logic unl_q;
   logic [7:0] fmt_q;
   logic [10:0] ivl_q;
   logic [15:0] off_q;
   // bus answer
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   // scheduler
   logic [2:0] tick_s;
   logic [10:0] eff_q;
   logic [10:0] cnt_q;
   logic req_q;
   logic [31:0] utc_q;
   // framer
   usc_tst_t st_q;
   usc_pkg::usc_rd_t hold_q;
   logic [1:0] bc_q;
   logic rdy_q;
   logic txv_q;
   logic [7:0] txb_q;
   logic txl_q;
   usc_pkg::usc_cfg_t cfg;

   usc_dl_parse u_parse (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .dl(dl),
      .rx_window(rx_window),
      .cfg(cfg)
   );

   // apb decode
   wire acc = apb.psel & apb.penable & ~pready_q;
   wire done = apb.psel & apb.penable & pready_q;
   wire h_ctrl = apb.paddr == usc_pkg::A_CTRL;
   wire h_ivl = apb.paddr == usc_pkg::A_IVL;
   wire h_off = apb.paddr == usc_pkg::A_OFF;
   wire h_key = apb.paddr == usc_pkg::A_KEY;
   wire h_stat = apb.paddr == usc_pkg::A_STAT;
   wire mapped = h_ctrl | h_ivl | h_off | h_key | h_stat;
   wire cfg_hit = h_ctrl | h_ivl | h_off;
   wire locked = lock_q & ~unl_q;
   // refused: unmapped, locked config write, bad interval, status write
   wire err_d = ~mapped | (apb.pwrite & ((cfg_hit & locked)
                | (h_ivl & ~ivl_ok(apb.pwdata)) | h_stat));
   wire wr = done & apb.pwrite & ~pslverr_q;
   wire [31:0] rd_ctrl = {16'h0000, fmt_q, 5'h00, lock_q, two_q, mode_q};
   wire [31:0] rd_stat = {5'h00, locked, data_rate, cnt_q, eff_q, req_q};
   wire [31:0] rdata_d = h_ctrl ? rd_ctrl :
                         h_ivl ? {21'h000000, ivl_q} :
                         h_off ? {16'h0000, off_q} :
                         h_stat ? rd_stat : 32'h0000_0000;

   // downlink commands need no key, as the server is trusted
   wire dl_ivl = cfg.valid & (cfg.ctype == usc_pkg::DLT_IVL) & ivl_ok(cfg.value);
   wire dl_mode = cfg.valid & (cfg.ctype == usc_pkg::DLT_MODE);
   wire dl_off = cfg.valid & (cfg.ctype == usc_pkg::DLT_OFF);
   wire dl_lock = cfg.valid & (cfg.ctype == usc_pkg::DLT_LOCK);
   wire dl_fmt = cfg.valid & (cfg.ctype == usc_pkg::DLT_FMT);

   // scheduler terms
   wire tick = tick_s[1] & ~tick_s[2];
   wire [10:0] floor_d = eco_min(data_rate, two_q);
   wire [10:0] eff_d = (mode_q && ivl_q < floor_d) ? floor_d : ivl_q;
   wire [31:0] off_ext = {{16{off_q[15]}}, off_q};

   // framer terms
   wire plain = fmt_q == usc_pkg::FMT_PLAIN;
   wire tx_free = ~txv_q | tx_ready;
   wire rd_take = rd.valid & rdy_q;
   wire [7:0] dat_b = hold_q.data[{bc_q, 3'b000} +: 8];

   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;
   assign uplink_req = req_q;
   assign eff_interval = eff_q;
   assign utc_time = utc_q;
   assign rd_ready = rdy_q;
   assign tx_valid = txv_q;
   assign tx_byte = txb_q;
   assign tx_last = txl_q;

   // apb answer: one wait state, data and error ready with pready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else if (ce) begin
         pready_q <= acc;
         pslverr_q <= acc & err_d;
         if (acc) begin
            prdata_q <= apb.pwrite ? 32'h0000_0000 : rdata_d;
         end
      end
   end

   // control register; bus writes win over a same-cycle downlink
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= usc_pkg::RST_MODE;
         two_q <= 1'b0;
         lock_q <= 1'b0;
         fmt_q <= usc_pkg::RST_FMT;
      end else if (ce) begin
         if (wr & h_ctrl) begin
            mode_q <= apb.pwdata[usc_pkg::C_MODE];
            two_q <= apb.pwdata[usc_pkg::C_TWO];
            lock_q <= apb.pwdata[usc_pkg::C_LOCK];
            fmt_q <= apb.pwdata[usc_pkg::C_FMT +: 8];
         end else begin
            if (dl_mode) begin
               mode_q <= cfg.value[usc_pkg::C_MODE];
               two_q <= cfg.value[usc_pkg::C_TWO];
            end
            if (dl_lock) lock_q <= cfg.value[0];
            if (dl_fmt) fmt_q <= cfg.value[7:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ivl_q <= usc_pkg::RST_IVL;
         off_q <= 16'h0000;
      end else if (ce) begin
         if (wr & h_ivl) ivl_q <= apb.pwdata[10:0];
         else if (dl_ivl) ivl_q <= cfg.value[10:0];
         if (wr & h_off) off_q <= apb.pwdata[15:0];
         else if (dl_off) off_q <= cfg.value[15:0];
      end
   end

   // key unlocks until a wrong key is written or the lock is dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unl_q <= 1'b0;
      end else if (ce) begin
         if (wr & h_key) unl_q <= apb.pwdata == DEV_KEY;
         else if (~lock_q) unl_q <= 1'b0;
      end
   end

   // minute tick from the meter clock is the only time base
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) tick_s <= 3'h0;
      else if (ce) tick_s <= {tick_s[1:0], minute_tick_pin};
   end

   // clamp re-evaluated every cycle; a rate change reaches eff_q next cycle, the countdown only at its next reload
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) eff_q <= usc_pkg::RST_IVL;
      else if (ce) eff_q <= eff_d;
   end

   // countdown in minutes; request holds until the uplink completes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= usc_pkg::RST_IVL;
         req_q <= 1'b0;
      end else if (ce) begin
         if (uplink_done) begin
            cnt_q <= eff_q;
            req_q <= 1'b0;
         end else if (tick && cnt_q != 11'h000) begin
            cnt_q <= cnt_q - 11'h001;
            if (cnt_q == 11'h001) req_q <= 1'b1;
         end
      end
   end

   // meter time is standard time; any daylight flag is never looked at
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) utc_q <= 32'h0000_0000;
      else if (ce) utc_q <= (off_q == 16'h0000) ? meter_time : meter_time - off_ext;
   end

   // telegram framer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= T_IDLE;
         hold_q <= '0;
         bc_q <= 2'h0;
         rdy_q <= 1'b0;
      end else if (ce) begin
         case (st_q)
            T_IDLE: if (tel_start) begin
               st_q <= plain ? T_DIB : T_FMT;
               rdy_q <= plain;
            end
            T_FMT: if (tx_free) begin
               st_q <= T_DIB;
               rdy_q <= 1'b1;
            end
            T_DIB: if (rd_take) begin
               hold_q <= rd;
               rdy_q <= 1'b0;
               bc_q <= 2'h0;
               st_q <= plain ? T_DAT : T_DIF;
            end
            T_DIF: if (tx_free) st_q <= T_VIF;
            T_VIF: if (tx_free) st_q <= T_DAT;
            T_DAT: if (tx_free) begin
               bc_q <= bc_q + 2'h1;
               if (bc_q == usc_pkg::DAT_LAST) begin
                  st_q <= hold_q.last ? T_IDLE : T_DIB;
                  rdy_q <= ~hold_q.last;
               end
            end
            default: st_q <= T_IDLE;
         endcase
      end
   end

   // byte register; data goes out least significant byte first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txv_q <= 1'b0;
         txb_q <= 8'h00;
         txl_q <= 1'b0;
      end else if (ce && tx_free) begin
         txv_q <= st_q inside {T_FMT, T_DIF, T_VIF, T_DAT};
         txl_q <= st_q == T_DAT && bc_q == usc_pkg::DAT_LAST && hold_q.last;
         case (st_q)
            T_FMT: txb_q <= fmt_q;
            T_DIF: txb_q <= hold_q.err ? (hold_q.dif | usc_pkg::DIF_ERR) : hold_q.dif;
            T_VIF: txb_q <= hold_q.vif;
            T_DAT: txb_q <= dat_b;
            default: txb_q <= txb_q;
         endcase
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_setup;
      apb.psel && !apb.penable;
   endsequence
   sequence s_wait;
      apb.psel && apb.penable && !pready;
   endsequence

   a_apb_answer: assert property (ce throughout (s_setup ##1 s_wait) |=> pready)
      else $error("pready missing one cycle after access start");
   a_ivl_range: assert property (ivl_q >= usc_pkg::IVL_MIN && ivl_q <= usc_pkg::IVL_MAX)
      else $error("configured interval out of range");
   a_eco_floor: assert property (ce && mode_q |=> eff_q >= $past(floor_d))
      else $error("interval in use below data rate minimum");
   a_eco_dr0: assert property (ce && mode_q && !two_q && data_rate == 3'h0
      && ivl_q < 11'h0B4 |=> eff_q == 11'h0B4)
      else $error("DR0 minimum not 180 minutes");
   a_eco_two: assert property (ce && mode_q && two_q && data_rate == 3'h5
      && ivl_q < 11'h01E |=> eff_q == 11'h01E)
      else $error("two-telegram DR5 minimum not 30 minutes");
   a_dl_window: assert property ($rose(dl_ivl) |-> $past(rx_window, 1))
      else $error("downlink command taken outside receive window");
   a_utc_shift: assert property (ce |=> utc_time == $past(meter_time) - $past(off_ext))
      else $error("timestamp not shifted by offset");
   a_utc_zero: assert property (ce && off_q == 16'h0000 |=> utc_time == $past(meter_time))
      else $error("zero offset changed the timestamp");
   a_lock_refuse: assert property (done && apb.pwrite && cfg_hit && locked |-> pslverr)
      else $error("locked configuration write not refused");
   a_fmt_first: assert property (ce && st_q == T_FMT && tx_free |=> tx_valid && tx_byte == fmt_q)
      else $error("telegram does not open with format byte");
   a_err_dif: assert property (ce && st_q == T_DIF && tx_free && hold_q.err
      |=> tx_byte[5:4] == 2'b11)
      else $error("error bits missing in data information field");
   a_plain_path: assert property (ce && st_q == T_DIB && rd_take && plain |=> st_q == T_DAT)
      else $error("plain text used block structure");
   a_reload: assert property (ce && uplink_done |=> cnt_q == $past(eff_q) && !uplink_req)
      else $error("counter not reloaded after uplink");
   a_req_hold: assert property (ce && uplink_req && !uplink_done |=> uplink_req)
      else $error("uplink request dropped before uplink done");
   a_tick_count: assert property (ce && tick && !uplink_done && cnt_q != 11'h000
      |=> cnt_q == $past(cnt_q) - 11'h001)
      else $error("minute tick did not step the counter");
   a_dl_apply: assert property (ce && dl_ivl && !(wr && h_ivl) |=> ivl_q == $past(cfg.value[10:0]))
      else $error("downlink interval command not applied");
   a_last_byte: assert property (ce && st_q == T_DAT && tx_free && bc_q == usc_pkg::DAT_LAST
      && hold_q.last |=> tx_last)
      else $error("last data byte of telegram not marked");
endmodule // usc_top

/* File: verif/usc_far_model.sv */
// radio mac stand-in: sends downlink frames, sinks telegram bytes
`timescale 1ns/1ps
module usc_far_model (
   // clock
   input wire logic pclk,
   // downlink side
   output usc_pkg::usc_dl_t dl,
   output logic rx_window,
   // telegram side
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   input wire logic tx_last,
   output logic tx_ready
);
   logic [8:0] rx_q[$];
   logic stall = 1'b0;
   int cyc = 0;

   initial begin
      dl = '0;
      rx_window = 1'b0;
      tx_ready = 1'b1;
   end

   // slow mode takes one byte in four, so the framer must hold its byte
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      tx_ready <= !stall || (cyc % 4 == 0);
      if (tx_valid && tx_ready) rx_q.push_back({tx_last, tx_byte});
   end

   // bytes go out from the top of b; released data shows the inverse of the last byte
   task automatic send(input logic [7:0] port, input logic win, input int n,
         input logic [47:0] b);
      logic [7:0] lb;
      lb = 8'h00;
      @(posedge pclk);
      rx_window <= win;
      for (int i = 0; i < n; i++) begin
         lb = b[47 - 8 * i -: 8];
         dl <= '{1'b1, port, lb, i == n - 1};
         @(posedge pclk);
      end
      dl <= '{1'b0, port, ~lb, 1'b0};
      repeat (3) @(posedge pclk);
      rx_window <= 1'b0;
   endtask
endmodule // usc_far_model

/* File: verif/testbench.sv */
// self-checking bench for the uplink schedule and configuration block
`timescale 1ns/1ps
module testbench;
   localparam logic [31:0] KEY = 32'hA5C3_0F1E; // arbitrary value
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   usc_pkg::usc_apb_req_t apb = '0;
   logic pready, pslverr, uplink_req, rd_ready, tx_valid, tx_last, tx_ready, rx_window, err;
   logic [31:0] prdata, utc_time, rdv;
   logic [31:0] meter_time = '0;
   logic [31:0] seed = 32'h6714764C;
   logic minute_tick_pin = 1'b0;
   logic uplink_done = 1'b0;
   logic tel_start = 1'b0;
   logic [2:0] data_rate = 3'h5;
   logic [10:0] eff_interval;
   logic [7:0] tx_byte;
   usc_pkg::usc_dl_t dl;
   usc_pkg::usc_rd_t rd = '0;
   int error_cnt = 0;
   int check_count = 0;
   int bnd[5] = '{1440, 4, 5, 1441, 0};
   logic [8:0] exp_q[$];

   always #50 pclk = ~pclk;

   usc_top #(.DEV_KEY(KEY)) u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .apb(apb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .minute_tick_pin(minute_tick_pin),
      .meter_time(meter_time), .utc_time(utc_time), .data_rate(data_rate),
      .uplink_done(uplink_done), .dl(dl), .rx_window(rx_window), .uplink_req(uplink_req),
      .eff_interval(eff_interval), .rd(rd), .tel_start(tel_start), .rd_ready(rd_ready),
      .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last));

   usc_far_model u_far (.pclk(pclk), .dl(dl), .rx_window(rx_window), .tx_valid(tx_valid),
      .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic int eco_min(input int dr, input int two);
      int t[6];
      t = '{180, 120, 60, 30, 15, 15};
      return t[dr] * (two + 1);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_tel();
      chk(u_far.rx_q.size(), exp_q.size());
      foreach (exp_q[i]) if (i < u_far.rx_q.size()) chk(u_far.rx_q[i], exp_q[i]);
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // request held until pready is seen high at a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      apb <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      apb.penable <= 1'b1;
      // only the watchdog ends a wait that never gets its answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdv = prdata;
      err = pslverr;
      apb <= '0;
   endtask

   task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic e);
      bus(1'b1, a, d);
      chk({31'h0, err}, {31'h0, e});
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rdv, exp);
   endtask

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge pclk);
         minute_tick_pin <= 1'b1;
         repeat (2) @(posedge pclk);
         minute_tick_pin <= 1'b0;
         repeat (5) @(posedge pclk);
      end
   endtask

   task automatic pulse_done();
      @(posedge pclk);
      uplink_done <= 1'b1;
      @(posedge pclk);
      uplink_done <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic tel(input logic [7:0] fmt, input logic e);
      logic [31:0] v;
      int n;
      v = rnd();
      n = 0;
      exp_q.delete();
      if (fmt != usc_pkg::FMT_PLAIN) begin
         exp_q.push_back({1'b0, fmt});
         exp_q.push_back({1'b0, e ? (8'h02 | usc_pkg::DIF_ERR) : 8'h02});
         exp_q.push_back({1'b0, 8'h13});
      end
      for (int i = 0; i < 4; i++) exp_q.push_back({i == 3, v[8 * i +: 8]});
      u_far.rx_q.delete();
      @(posedge pclk);
      tel_start <= 1'b1;
      rd <= '{1'b1, e, 1'b1, 8'h02, 8'h13, v};
      do begin
         @(posedge pclk);
         tel_start <= 1'b0;
         n++;
      end while (rd_ready !== 1'b1 && n < 50);
      rd <= '0;
      while (u_far.rx_q.size() < exp_q.size() && n < 400) begin
         @(posedge pclk);
         n++;
      end
   endtask

   // about ten thousand cycles, several times the expected run
   initial begin
      #1_000_000;
      error_cnt++;
      stop_test();
   end

   initial begin
      int ivl;
      logic e;
      ivl = 60;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rdc(usc_pkg::A_CTRL, 32'h0000_1501);
      rdc(usc_pkg::A_IVL, 32'h3C);
      rdc(usc_pkg::A_KEY, 32'h0);
      wrc(8'h14, 32'h0, 1'b1);
      wrc(usc_pkg::A_STAT, 32'h0, 1'b1);
      $display("test registers done");
      foreach (bnd[i]) begin
         e = bnd[i] < 5 || bnd[i] > 1440;
         if (!e) ivl = bnd[i];
         wrc(usc_pkg::A_IVL, bnd[i], e);
         rdc(usc_pkg::A_IVL, ivl);
      end
      for (int two = 0; two < 2; two++) begin
         wrc(usc_pkg::A_CTRL, {16'h0, 8'h15, 6'h0, two[0], 1'b1}, 1'b0);
         for (int dr = 0; dr < 6; dr++) begin
            data_rate <= dr[2:0];
            repeat (4) @(posedge pclk);
            chk(eff_interval, eco_min(dr, two));
         end
      end
      wrc(usc_pkg::A_IVL, 32'd200, 1'b0);
      data_rate <= 3'h0;
      repeat (4) @(posedge pclk);
      chk(eff_interval, 32'd360);
      wrc(usc_pkg::A_CTRL, 32'h1500, 1'b0);
      repeat (2) @(posedge pclk);
      chk(eff_interval, 32'd200);
      $display("test interval done");
      wrc(usc_pkg::A_IVL, 32'd5, 1'b0);
      pulse_done();
      chk(uplink_req, 32'h0);
      tick(4);
      chk(uplink_req, 32'h0);
      tick(1);
      chk(uplink_req, 32'h1);
      pulse_done();
      chk(uplink_req, 32'h0);
      rdc(usc_pkg::A_STAT, 32'h0000_500A);
      $display("test scheduler done");
      for (int i = 0; i < 2; i++) begin
         wrc(usc_pkg::A_OFF, i * 60, 1'b0);
         meter_time <= rnd();
         repeat (3) @(posedge pclk);
         chk(utc_time, meter_time - i * 60);
      end
      u_far.send(8'h02, 1'b1, 5, 48'h00_01_02_00_B4_00);
      repeat (3) @(posedge pclk);
      rdc(usc_pkg::A_IVL, 32'd180);
      u_far.send(8'h03, 1'b1, 5, 48'h00_01_02_00_0A_00);
      u_far.send(8'h02, 1'b0, 5, 48'h00_01_02_00_0A_00);
      u_far.send(8'h02, 1'b1, 5, 48'h01_01_02_00_0A_00);
      u_far.send(8'h02, 1'b1, 4, 48'h00_01_02_00_0A_00);
      rdc(usc_pkg::A_IVL, 32'd180);
      u_far.send(8'h02, 1'b1, 5, 48'h00_03_02_FE_D4_00);
      repeat (3) @(posedge pclk);
      chk(utc_time, meter_time + 300);
      u_far.send(8'h02, 1'b1, 4, 48'h00_02_01_03_00_00);
      rdc(usc_pkg::A_CTRL, 32'h0000_1503);
      u_far.send(8'h02, 1'b1, 4, 48'h00_05_01_16_00_00);
      rdc(usc_pkg::A_CTRL, 32'h0000_1603);
      $display("test downlink done");
      wrc(usc_pkg::A_CTRL, 32'h1504, 1'b0);
      wrc(usc_pkg::A_IVL, 32'd100, 1'b1);
      wrc(usc_pkg::A_KEY, ~KEY, 1'b0);
      wrc(usc_pkg::A_IVL, 32'd100, 1'b1);
      wrc(usc_pkg::A_KEY, KEY, 1'b0);
      wrc(usc_pkg::A_IVL, 32'd100, 1'b0);
      rdc(usc_pkg::A_IVL, 32'd100);
      wrc(usc_pkg::A_CTRL, 32'h1500, 1'b0);
      $display("test lock done");
      u_far.stall <= 1'b1;
      tel(usc_pkg::RST_FMT, 1'b1);
      chk_tel();
      wrc(usc_pkg::A_CTRL, {16'h0, usc_pkg::FMT_PLAIN, 8'h00}, 1'b0);
      tel(usc_pkg::FMT_PLAIN, 1'b0);
      chk_tel();
      $display("test telegram done");
      stop_test();
   end
endmodule // testbench
